// ==== icc_pkg.sv ====
// Shared constants, types and register map of the interleave correction control bank.
package icc_pkg;

   // ==========================================================================
   // Register offsets
   localparam logic [7:0] ADDR_PWR_SEL     = 8'h25;
   localparam logic [7:0] ADDR_OFS_COARSE  = 8'h26;
   localparam logic [7:0] ADDR_OFS_FINE    = 8'h27;
   localparam logic [7:0] ADDR_GAIN_COARSE = 8'h28;
   localparam logic [7:0] ADDR_GAIN_MEDIUM = 8'h29;
   localparam logic [7:0] ADDR_GAIN_FINE   = 8'h2a;
   localparam logic [7:0] ADDR_STATUS      = 8'h30;
   localparam logic [7:0] ADDR_CONTROL     = 8'h31;
   localparam logic [7:0] ADDR_STATIC      = 8'h32;
   localparam logic [7:0] ADDR_ENG_PD      = 8'h4a;
   localparam logic [7:0] ADDR_THR_LOW     = 8'h50;
   localparam logic [7:0] ADDR_THR_HIGH    = 8'h51;
   localparam logic [7:0] ADDR_HYST        = 8'h52;

   // ==========================================================================
   // Field positions
   localparam int CTRL_ON_BIT       = 0;
   localparam int CTRL_FREEZE_BIT   = 1;
   localparam int CTRL_DIS_OFS_BIT  = 2;
   localparam int CTRL_DIS_GAIN_BIT = 3;
   localparam int CTRL_DIS_SKEW_BIT = 4;
   localparam int CTRL_NOTCH_BIT    = 5;
   localparam int STAT_LOW_PWR_BIT  = 0;
   localparam int STAT_LOW_AC_BIT   = 1;
   localparam int STAT_SETTLED_BIT  = 2;
   localparam int STATIC_SKIP_BIT   = 5;
   localparam int PD_ALG_BIT        = 0;
   localparam int PD_NOTCH_BIT      = 1;
   localparam int THR_LSB           = 4;
   localparam int HYST_LSB          = 4;
   localparam int SAMPLE_W          = 12;
   localparam int POWER_W           = 24;

   // ==========================================================================
   // Power-down field codes and reset values
   localparam logic [2:0]  PD_PIN        = 3'h0;
   localparam logic [2:0]  PD_NORMAL     = 3'h1;
   localparam logic [2:0]  PD_NAP        = 3'h2;
   localparam logic [2:0]  PD_SLEEP      = 3'h4;
   localparam logic [7:0]  BYTE_RESET    = 8'h00;
   localparam logic [15:0] THR_RESET     = 16'h1000;
   localparam logic [7:0]  HYST_RESET    = 8'h00;

   // ==========================================================================
   // Timing
   localparam int CLK_PERIOD_NS  = 40;
   localparam int METER_TIME_NS  = 1000;
   localparam int METER_CYCLES   = METER_TIME_NS / CLK_PERIOD_NS;
   localparam int SETTLE_TIME_MS = 1000;
   localparam int SETTLE_CYCLES  = SETTLE_TIME_MS * (1000000 / CLK_PERIOD_NS);
   localparam int COARSE_CYCLES  = 1024;
   localparam int AVG_LOG2       = 4;

   // ==========================================================================
   // Types
   typedef enum logic [1:0] {
      ICC_PS_NORMAL = 2'h0,
      ICC_PS_NAP    = 2'h1,
      ICC_PS_SLEEP  = 2'h2
   } icc_pwr_state_t;

   typedef enum logic [3:0] {
      ICC_ENG_OFF    = 4'h1,
      ICC_ENG_COARSE = 4'h2,
      ICC_ENG_SETTLE = 4'h4,
      ICC_ENG_RUN    = 4'h8
   } icc_eng_state_t;

   typedef struct packed {
      logic [7:0] ofsCoarse;
      logic [7:0] ofsFine;
      logic [3:0] gainCoarse;
      logic [7:0] gainMedium;
      logic [7:0] gainFine;
   } icc_trims_t;

   typedef struct packed {
      logic       write;
      logic       read;
      logic [7:0] addr;
      logic [7:0] wdata;
   } icc_reg_req_t;

   typedef struct packed {
      logic engineActive;
      logic coarsePhase;
      logic skipCoarse;
      logic updateOffset;
      logic updateGain;
      logic updateSkew;
      logic notchEnable;
      logic algPowerDown;
      logic notchPowerDown;
   } icc_eng_cmd_t;

endpackage

// ==== icc_power_meter.sv ====
// RMS power meter with threshold and hysteresis that decides the hold state.
module icc_power_meter #(
   parameter int WINDOW   = icc_pkg::METER_CYCLES,
   parameter int AVG_LOG2 = icc_pkg::AVG_LOG2
) (
   // Clock and reset
   input  wire logic                         core_clk,
   input  wire logic                         nrst,
   // Control
   input  wire logic                         enable,
   input  wire logic [icc_pkg::SAMPLE_W-1:0] sample,
   input  wire logic [icc_pkg::POWER_W-1:0]  threshold,
   input  wire logic [icc_pkg::POWER_W-1:0]  hysteresis,
   // Result
   output logic                              lowPower
);

   localparam int CNT_W = $clog2(WINDOW + 1);
   localparam int ACC_W = icc_pkg::POWER_W + AVG_LOG2;
   localparam logic [CNT_W-1:0] LAST  = CNT_W'(WINDOW - 1);
   localparam logic [CNT_W-1:0] NAVG  = CNT_W'(2 ** AVG_LOG2);

   typedef struct packed {
      logic [CNT_W-1:0] cnt;
      logic [ACC_W-1:0] acc;
      logic             hold;
   } icc_meter_state_t;

   icc_meter_state_t st_r;
   icc_meter_state_t st_nxt;
   logic [icc_pkg::POWER_W-1:0] square;
   logic [icc_pkg::POWER_W-1:0] average;
   logic [icc_pkg::POWER_W:0]   release_lvl;

   always_comb begin
      square      = icc_pkg::POWER_W'($signed(sample) * $signed(sample));
      average     = icc_pkg::POWER_W'(st_r.acc >> AVG_LOG2);
      release_lvl = {1'b0, threshold} + {1'b0, hysteresis};
      st_nxt      = st_r;
      if (!enable) begin
         st_nxt.cnt  = '0;
         st_nxt.acc  = '0;
         st_nxt.hold = 1'b0;
      end else begin
         if (st_r.cnt < NAVG) begin
            st_nxt.acc = st_r.acc + ACC_W'(square);
         end
         if (st_r.cnt == LAST) begin
            st_nxt.cnt = '0;
            st_nxt.acc = '0;
            // Once in hold, only threshold plus hysteresis or disabling the meter brings tracking back.
            if (!st_r.hold && (average < threshold)) begin
               st_nxt.hold = 1'b1;
            end else if (st_r.hold && ({1'b0, average} >= release_lvl)) begin
               st_nxt.hold = 1'b0;
            end
         end else begin
            st_nxt.cnt = st_r.cnt + CNT_W'(1);
         end
      end
   end

   always_ff @(posedge core_clk) begin
      if (!nrst) begin
         st_r <= '0;
      end else begin
         st_r <= st_nxt;
      end
   end

   assign lowPower = st_r.hold;

endmodule // icc_power_meter

// ==== icc_regs.sv ====
// Register bank and engine sequencing of the interleave correction control block.
//
// Summary of operation
// - Power field: 000 pin, 001 normal, 010 nap, 100 sleep.
// - Power-down select register ignores soft reset.
// - Core 1 coarse and fine offset trims are eight-bit two's complement.
// - Core 1 trims take the self-calibration result after power-up.
// - Offset, medium and fine gain trims apply only while adjust enable is high.
// - Coarse gain is four independent step bits; medium and fine are eight bits.
// - Status bit 0 shows low power hold with gain and skew adjustments frozen.
// - Status bit 1 shows low AC power; estimates stop updating meanwhile.
// - Status bit 2 is zero while settling, one when settled.
// - Control bit 0 turns engine on; control writable while running.
// - Control bit 1 freezes engine; clearing resumes from frozen state.
// - Control bits 2 to 4 disable offset, gain and skew adjustment.
// - Control bit 5 routes samples through the quarter-rate notch filter.
// - Static bit 5 skips the initial coarse adjustment at turn-on.
// - Engine power-down: bit 0 algorithm, bit 1 notch filter.
// - Meter squares upper 12 sample bits, averages, compares about every microsecond.
// - Threshold pair sits in bits 19 to 4 of a 24-bit value.
// - Threshold resets to 0x1000; power below it enters hold.
// - Power hold stops gain and skew updates only, not offset.
// - Leaving hold needs threshold plus hysteresis in bits 11 to 4.
// - Soft reset returns registers to defaults except those exempted.
module icc_regs #(
   parameter int SETTLE_CYCLES = icc_pkg::SETTLE_CYCLES,
   parameter int COARSE_CYCLES = icc_pkg::COARSE_CYCLES
) (
   // Clock and reset
   input  wire logic                         core_clk,
   input  wire logic                         nrst,
   // Register port from the serial engine
   input  wire icc_pkg::icc_reg_req_t        regReq,
   output logic [7:0]                        regRdData,
   output logic                              regRdValid,
   // Global controls from other registers
   input  wire logic                         softReset,
   input  wire logic                         adjustEnable,
   // Self-calibration result
   input  wire logic                         calLoad,
   input  wire icc_pkg::icc_trims_t          calTrims,
   // Pin and data path
   input  wire logic [1:0]                   powerStatePin,
   input  wire logic [icc_pkg::SAMPLE_W-1:0] sample,
   input  wire logic                         acLowPower,
   // Results
   output icc_pkg::icc_pwr_state_t           powerState,
   output icc_pkg::icc_trims_t               appliedTrims,
   output icc_pkg::icc_eng_cmd_t             engineCmd
);

   localparam int CNT_W = 32;

   // ==========================================================================
   // State
   typedef struct packed {
      logic [1:0]              pinMeta;
      logic [1:0]              pinSync;
      logic [7:0]              pwrSel;
      icc_pkg::icc_pwr_state_t pwrState;
      icc_pkg::icc_trims_t     trims;
      icc_pkg::icc_trims_t     calCopy;
      icc_pkg::icc_trims_t     applied;
      logic [7:0]              control;
      logic [7:0]              staticCtl;
      logic [7:0]              engPd;
      logic [15:0]             threshold;
      logic [7:0]              hysteresis;
      icc_pkg::icc_eng_state_t engState;
      logic                    skipLatched;
      logic [CNT_W-1:0]        phaseCnt;
      logic [7:0]              rdData;
      logic                    rdValid;
   } icc_regs_state_t;

   localparam icc_regs_state_t RESET_STATE = '{
      pinMeta:     2'h0,
      pinSync:     2'h0,
      pwrSel:      icc_pkg::BYTE_RESET,
      pwrState:    icc_pkg::ICC_PS_NORMAL,
      trims:       '0,
      calCopy:     '0,
      applied:     '0,
      control:     icc_pkg::BYTE_RESET,
      staticCtl:   icc_pkg::BYTE_RESET,
      engPd:       icc_pkg::BYTE_RESET,
      threshold:   icc_pkg::THR_RESET,
      hysteresis:  icc_pkg::HYST_RESET,
      engState:    icc_pkg::ICC_ENG_OFF,
      skipLatched: 1'b0,
      phaseCnt:    '0,
      rdData:      icc_pkg::BYTE_RESET,
      rdValid:     1'b0
   };

   localparam logic [CNT_W-1:0] SETTLE_LAST = CNT_W'(SETTLE_CYCLES - 1);
   localparam logic [CNT_W-1:0] COARSE_LAST = CNT_W'(COARSE_CYCLES - 1);

   icc_regs_state_t st_r;
   icc_regs_state_t st_nxt;

   logic [icc_pkg::POWER_W-1:0] thrWide;
   logic [icc_pkg::POWER_W-1:0] hystWide;
   logic                        meterHold;
   logic                        engineOn;
   logic                        frozen;
   logic                        running;
   logic [7:0]                  statusByte;

   // ==========================================================================
   // Power meter
   always_comb begin
      thrWide  = '0;
      hystWide = '0;
      thrWide[icc_pkg::THR_LSB +: 16]  = st_r.threshold;
      hystWide[icc_pkg::HYST_LSB +: 8] = st_r.hysteresis;
   end

   icc_power_meter #(
      .WINDOW   (icc_pkg::METER_CYCLES),
      .AVG_LOG2 (icc_pkg::AVG_LOG2)
   ) u_meter (
      .core_clk   (core_clk),
      .nrst       (nrst),
      .enable     (running),
      .sample     (sample),
      .threshold  (thrWide),
      .hysteresis (hystWide),
      .lowPower   (meterHold)
   );

   // ==========================================================================
   // Engine qualifiers
   always_comb begin
      engineOn = st_r.control[icc_pkg::CTRL_ON_BIT] && !st_r.engPd[icc_pkg::PD_ALG_BIT];
      frozen   = st_r.control[icc_pkg::CTRL_FREEZE_BIT];
      running  = (st_r.engState != icc_pkg::ICC_ENG_OFF) && !frozen;
      statusByte = '0;
      statusByte[icc_pkg::STAT_LOW_PWR_BIT] =
         (st_r.engState != icc_pkg::ICC_ENG_OFF) && meterHold;
      statusByte[icc_pkg::STAT_LOW_AC_BIT] =
         (st_r.engState != icc_pkg::ICC_ENG_OFF) && acLowPower;
      statusByte[icc_pkg::STAT_SETTLED_BIT] =
         (st_r.engState == icc_pkg::ICC_ENG_RUN);
   end

   // ==========================================================================
   // Next state
   always_comb begin
      st_nxt = st_r;

      // Power state pin crosses into the clock domain first.
      st_nxt.pinMeta = powerStatePin;
      st_nxt.pinSync = st_r.pinMeta;

      // Self-calibration result becomes the default of each trim.
      if (calLoad) begin
         st_nxt.calCopy = calTrims;
         st_nxt.trims   = calTrims;
      end

      // Soft reset restores defaults; the power-down select is exempt.
      if (softReset) begin
         st_nxt.trims      = st_r.calCopy;
         st_nxt.control    = icc_pkg::BYTE_RESET;
         st_nxt.staticCtl  = icc_pkg::BYTE_RESET;
         st_nxt.engPd      = icc_pkg::BYTE_RESET;
         st_nxt.threshold  = icc_pkg::THR_RESET;
         st_nxt.hysteresis = icc_pkg::HYST_RESET;
      end else if (regReq.write) begin
         case (regReq.addr)
            icc_pkg::ADDR_PWR_SEL: begin
               st_nxt.pwrSel = regReq.wdata;
            end
            icc_pkg::ADDR_OFS_COARSE: begin
               st_nxt.trims.ofsCoarse = regReq.wdata;
            end
            icc_pkg::ADDR_OFS_FINE: begin
               st_nxt.trims.ofsFine = regReq.wdata;
            end
            icc_pkg::ADDR_GAIN_COARSE: begin
               st_nxt.trims.gainCoarse = regReq.wdata[3:0];
            end
            icc_pkg::ADDR_GAIN_MEDIUM: begin
               st_nxt.trims.gainMedium = regReq.wdata;
            end
            icc_pkg::ADDR_GAIN_FINE: begin
               st_nxt.trims.gainFine = regReq.wdata;
            end
            icc_pkg::ADDR_CONTROL: begin
               st_nxt.control = regReq.wdata;
            end
            icc_pkg::ADDR_STATIC: begin
               st_nxt.staticCtl = regReq.wdata;
            end
            icc_pkg::ADDR_ENG_PD: begin
               st_nxt.engPd = regReq.wdata;
            end
            icc_pkg::ADDR_THR_LOW: begin
               st_nxt.threshold[7:0] = regReq.wdata;
            end
            icc_pkg::ADDR_THR_HIGH: begin
               st_nxt.threshold[15:8] = regReq.wdata;
            end
            icc_pkg::ADDR_HYST: begin
               st_nxt.hysteresis = regReq.wdata;
            end
            default: begin
               st_nxt.pwrSel = st_r.pwrSel;
            end
         endcase
      end

      // Offset and medium/fine gain reach the core only under adjust enable.
      st_nxt.applied.gainCoarse = st_r.trims.gainCoarse;
      if (adjustEnable) begin
         st_nxt.applied.ofsCoarse  = st_r.trims.ofsCoarse;
         st_nxt.applied.ofsFine    = st_r.trims.ofsFine;
         st_nxt.applied.gainMedium = st_r.trims.gainMedium;
         st_nxt.applied.gainFine   = st_r.trims.gainFine;
      end

      // Power state decode; reserved codes hold the previous state.
      case (st_r.pwrSel[2:0])
         icc_pkg::PD_PIN: begin
            case (st_r.pinSync)
               2'h1:    st_nxt.pwrState = icc_pkg::ICC_PS_NAP;
               2'h2:    st_nxt.pwrState = icc_pkg::ICC_PS_SLEEP;
               default: st_nxt.pwrState = icc_pkg::ICC_PS_NORMAL;
            endcase
         end
         icc_pkg::PD_NORMAL: begin
            st_nxt.pwrState = icc_pkg::ICC_PS_NORMAL;
         end
         icc_pkg::PD_NAP: begin
            st_nxt.pwrState = icc_pkg::ICC_PS_NAP;
         end
         icc_pkg::PD_SLEEP: begin
            st_nxt.pwrState = icc_pkg::ICC_PS_SLEEP;
         end
         default: begin
            st_nxt.pwrState = st_r.pwrState;
         end
      endcase

      // Engine sequencing. Freeze stalls the phase counter so the engine
      // resumes exactly where it stopped.
      if (!engineOn) begin
         st_nxt.engState = icc_pkg::ICC_ENG_OFF;
         st_nxt.phaseCnt = '0;
      end else if (!frozen) begin
         case (st_r.engState)
            icc_pkg::ICC_ENG_OFF: begin
               // Static settings are sampled only at turn-on.
               st_nxt.skipLatched = st_r.staticCtl[icc_pkg::STATIC_SKIP_BIT];
               st_nxt.phaseCnt    = '0;
               if (st_r.staticCtl[icc_pkg::STATIC_SKIP_BIT]) begin
                  st_nxt.engState = icc_pkg::ICC_ENG_SETTLE;
               end else begin
                  st_nxt.engState = icc_pkg::ICC_ENG_COARSE;
               end
            end
            icc_pkg::ICC_ENG_COARSE: begin
               if (st_r.phaseCnt == COARSE_LAST) begin
                  st_nxt.phaseCnt = '0;
                  st_nxt.engState = icc_pkg::ICC_ENG_SETTLE;
               end else begin
                  st_nxt.phaseCnt = st_r.phaseCnt + CNT_W'(1);
               end
            end
            icc_pkg::ICC_ENG_SETTLE: begin
               if (st_r.phaseCnt == SETTLE_LAST) begin
                  st_nxt.phaseCnt = '0;
                  st_nxt.engState = icc_pkg::ICC_ENG_RUN;
               end else begin
                  st_nxt.phaseCnt = st_r.phaseCnt + CNT_W'(1);
               end
            end
            icc_pkg::ICC_ENG_RUN: begin
               st_nxt.engState = icc_pkg::ICC_ENG_RUN;
            end
            default: begin
               st_nxt.engState = icc_pkg::ICC_ENG_OFF;
            end
         endcase
      end

      // Registered read answer; unmapped addresses read zero.
      st_nxt.rdValid = regReq.read;
      if (regReq.read) begin
         case (regReq.addr)
            icc_pkg::ADDR_PWR_SEL:     st_nxt.rdData = st_r.pwrSel;
            icc_pkg::ADDR_OFS_COARSE:  st_nxt.rdData = st_r.trims.ofsCoarse;
            icc_pkg::ADDR_OFS_FINE:    st_nxt.rdData = st_r.trims.ofsFine;
            icc_pkg::ADDR_GAIN_COARSE: st_nxt.rdData = {4'h0, st_r.trims.gainCoarse};
            icc_pkg::ADDR_GAIN_MEDIUM: st_nxt.rdData = st_r.trims.gainMedium;
            icc_pkg::ADDR_GAIN_FINE:   st_nxt.rdData = st_r.trims.gainFine;
            icc_pkg::ADDR_STATUS:      st_nxt.rdData = statusByte;
            icc_pkg::ADDR_CONTROL:     st_nxt.rdData = st_r.control;
            icc_pkg::ADDR_STATIC:      st_nxt.rdData = st_r.staticCtl;
            icc_pkg::ADDR_ENG_PD:      st_nxt.rdData = st_r.engPd;
            icc_pkg::ADDR_THR_LOW:     st_nxt.rdData = st_r.threshold[7:0];
            icc_pkg::ADDR_THR_HIGH:    st_nxt.rdData = st_r.threshold[15:8];
            icc_pkg::ADDR_HYST:        st_nxt.rdData = st_r.hysteresis;
            default:                   st_nxt.rdData = icc_pkg::BYTE_RESET;
         endcase
      end
   end

   // ==========================================================================
   // State register
   always_ff @(posedge core_clk) begin
      if (!nrst) begin
         st_r <= RESET_STATE;
      end else begin
         st_r <= st_nxt;
      end
   end

   // ==========================================================================
   // Outputs
   always_comb begin
      engineCmd              = '0;
      engineCmd.engineActive = running;
      engineCmd.coarsePhase  = (st_r.engState == icc_pkg::ICC_ENG_COARSE);
      engineCmd.skipCoarse   = st_r.skipLatched;
      engineCmd.updateOffset = running && !acLowPower
                               && !st_r.control[icc_pkg::CTRL_DIS_OFS_BIT];
      engineCmd.updateGain   = running && !acLowPower && !meterHold
                               && !st_r.control[icc_pkg::CTRL_DIS_GAIN_BIT];
      engineCmd.updateSkew   = running && !acLowPower && !meterHold
                               && !st_r.control[icc_pkg::CTRL_DIS_SKEW_BIT];
      engineCmd.notchEnable  = st_r.control[icc_pkg::CTRL_NOTCH_BIT]
                               && !st_r.engPd[icc_pkg::PD_NOTCH_BIT];
      engineCmd.algPowerDown   = st_r.engPd[icc_pkg::PD_ALG_BIT];
      engineCmd.notchPowerDown = st_r.engPd[icc_pkg::PD_NOTCH_BIT];
   end

   assign regRdData    = st_r.rdData;
   assign regRdValid   = st_r.rdValid;
   assign powerState   = st_r.pwrState;
   assign appliedTrims = st_r.applied;

endmodule // icc_regs

// ==== icc_regs_asserts.sv ====
// Port-level checks of the interleave correction register bank.
module icc_regs_asserts (
   // Clock and reset
   input wire logic                    core_clk,
   input wire logic                    nrst,
   // Register port and controls
   input wire icc_pkg::icc_reg_req_t   regReq,
   input wire logic                    softReset,
   input wire logic                    adjustEnable,
   input wire logic                    calLoad,
   input wire logic                    acLowPower,
   // Results
   input wire icc_pkg::icc_pwr_state_t powerState,
   input wire icc_pkg::icc_trims_t     appliedTrims,
   input wire icc_pkg::icc_eng_cmd_t   engineCmd
);
   // =====
   // Write decodes
   default clocking cb @(posedge core_clk); endclocking
   default disable iff (!nrst);
   logic wr;
   logic wPd;
   logic wCtl;
   assign wr = regReq.write && !softReset;
   assign wPd = wr && regReq.addr == 8'h25;
   assign wCtl = wr && regReq.addr == 8'h31;
   // =====
   // Properties
   a_pd_nap: assert property (wPd && regReq.wdata[2:0] == 3'h2
      |=> ##1 powerState == icc_pkg::ICC_PS_NAP) else $error("nap code not applied");
   a_pd_resv: assert property (wPd && !(regReq.wdata[2:0] inside {3'h0, 3'h1, 3'h2, 3'h4})
      |=> ##1 $stable(powerState)) else $error("reserved code moved power state");
   a_trim_hold: assert property (!adjustEnable && !calLoad && !softReset
      |=> $stable(appliedTrims.ofsCoarse)) else $error("trim applied while disabled");
   a_trim_apply: assert property (wr && regReq.addr == 8'h26 && adjustEnable ##1 adjustEnable
      |=> appliedTrims.ofsCoarse == $past(regReq.wdata, 2)) else $error("trim not applied");
   a_eng_pd: assert property (wr && regReq.addr == 8'h4a
      |=> {engineCmd.notchPowerDown, engineCmd.algPowerDown} == $past(regReq.wdata[1:0]))
      else $error("power-down bits wrong");
   a_freeze_all: assert property (wCtl && regReq.wdata[1]
      |=> !(engineCmd.updateOffset || engineCmd.updateGain || engineCmd.updateSkew))
      else $error("frozen engine still updates");
   a_dis_ofs: assert property (wCtl && regReq.wdata[2] |=> !engineCmd.updateOffset)
      else $error("offset update not disabled");
   a_eng_off: assert property (wCtl && !regReq.wdata[0] |=> ##1 !engineCmd.engineActive)
      else $error("engine not turned off");
   a_ac_low: assert property (acLowPower [*3] |-> !engineCmd.updateGain)
      else $error("gain updates during low AC power");
endmodule // icc_regs_asserts

// ==== icc_host_model.sv ====
// Register port master standing in for the serial host.
module icc_host_model (
   // Clock
   input wire logic              core_clk,
   // Register port
   output icc_pkg::icc_reg_req_t regReq,
   input wire logic [7:0]        regRdData,
   input wire logic              regRdValid
);
   timeunit 1ns;
   timeprecision 1ns;
   initial regReq = '0;
   task automatic wr(input logic [7:0] a, input logic [7:0] v);
      @(negedge core_clk);
      regReq.addr = a;
      regReq.wdata = (a == 8'h32) ? (v & 8'h61) : v;
      regReq.write = 1'b1;
      @(negedge core_clk);
      regReq.write = 1'b0;
      regReq.wdata = ~regReq.wdata;
   endtask
   task automatic rd(input logic [7:0] a, output logic [7:0] v);
      @(negedge core_clk);
      regReq.addr = a;
      regReq.read = 1'b1;
      @(negedge core_clk);
      regReq.read = 1'b0;
      v = regRdValid ? regRdData : 8'hxx;
   endtask
endmodule // icc_host_model

// ==== tb.sv ====
// Self-checking bench of the interleave correction register bank.
module tb;
   timeunit 1ns;
   timeprecision 1ns;
   // =====
   // Signals
   logic                    core_clk = 1'b0;
   logic                    nrst = 1'b0;
   logic                    softReset = 1'b0;
   logic                    adjustEnable = 1'b0;
   logic                    calLoad = 1'b0;
   logic                    acLowPower = 1'b0;
   logic [1:0]              powerStatePin = 2'h0;
   logic [11:0]             sample = 12'h7ff;
   icc_pkg::icc_trims_t     calTrims = '0;
   icc_pkg::icc_reg_req_t   regReq;
   icc_pkg::icc_pwr_state_t powerState;
   icc_pkg::icc_trims_t     appliedTrims;
   icc_pkg::icc_eng_cmd_t   engineCmd;
   logic [7:0]              regRdData;
   logic                    regRdValid;
   logic [7:0]              d;
   int                      bad_count = 0;
   int                      compares = 0;
   always #20 core_clk = ~core_clk;
   icc_host_model hostU (.core_clk(core_clk), .regReq(regReq), .regRdData(regRdData),
      .regRdValid(regRdValid));
   icc_regs #(.SETTLE_CYCLES(20), .COARSE_CYCLES(40)) dut_u (.core_clk(core_clk), .nrst(nrst),
      .regReq(regReq), .regRdData(regRdData), .regRdValid(regRdValid), .softReset(softReset),
      .adjustEnable(adjustEnable), .calLoad(calLoad), .calTrims(calTrims),
      .powerStatePin(powerStatePin), .sample(sample), .acLowPower(acLowPower),
      .powerState(powerState), .appliedTrims(appliedTrims), .engineCmd(engineCmd));
   // =====
   // Helpers
   task automatic chk(input logic [7:0] seen, input logic [7:0] exp);
      compares++;
      if (seen !== exp) begin
         bad_count++;
         $display("BAD %0t seen %h expected %h", $time, seen, exp);
      end
   endtask
   task automatic rc(input logic [7:0] a, input logic [7:0] exp);
      hostU.rd(a, d);
      chk(d, exp);
   endtask
   task automatic wrap_up;
      $display("compares %0d bad_count %0d", compares, bad_count);
      if (bad_count == 0 && compares > 0) $display("Run complete: PASS");
      else $display("Run complete: FAIL");
      $finish;
   endtask
   // =====
   // Scenarios
   task automatic t_power;
      logic [2:0] code [4] = '{3'h1, 3'h2, 3'h4, 3'h3};
      logic [1:0] want [4] = '{2'h0, 2'h1, 2'h2, 2'h2};
      rc(8'h51, 8'h10);
      rc(8'h7f, 8'h00);
      for (int i = 0; i < 4; i++) begin
         hostU.wr(8'h25, {5'h00, code[i]});
         repeat (2) @(negedge core_clk);
         chk({6'h00, powerState}, {6'h00, want[i]});
      end
      powerStatePin = 2'h1;
      hostU.wr(8'h25, 8'h00);
      repeat (6) @(negedge core_clk);
      chk({6'h00, powerState}, 8'h01);
      hostU.wr(8'h25, 8'h02);
      hostU.wr(8'h50, 8'h34);
      softReset = 1'b1;
      @(negedge core_clk);
      softReset = 1'b0;
      rc(8'h25, 8'h02);
      rc(8'h50, 8'h00);
      $display("t_power done");
   endtask
   task automatic t_trims;
      adjustEnable = 1'b1;
      calTrims = '{8'h11, 8'h22, 4'h3, 8'h44, 8'h55};
      calLoad = 1'b1;
      @(negedge core_clk);
      calLoad = 1'b0;
      @(negedge core_clk);
      adjustEnable = 1'b0;
      rc(8'h27, 8'h22);
      hostU.wr(8'h26, 8'h80);
      hostU.wr(8'h28, 8'h0c);
      rc(8'h26, 8'h80);
      chk(appliedTrims.ofsCoarse, 8'h11);
      chk({4'h0, appliedTrims.gainCoarse}, 8'h0c);
      adjustEnable = 1'b1;
      hostU.wr(8'h26, 8'h90);
      @(negedge core_clk);
      chk(appliedTrims.ofsCoarse, 8'h90);
      $display("t_trims done");
   endtask
   task automatic t_engine;
      hostU.wr(8'h32, 8'hff);
      hostU.wr(8'h31, 8'h21);
      rc(8'h30, 8'h00);
      for (int i = 0; i < 13 && d[2] !== 1'b1; i++) hostU.rd(8'h30, d);
      chk({7'h00, d[2]}, 8'h01);
      if (d[2] !== 1'b1) wrap_up();
      chk({7'h00, engineCmd.notchEnable}, 8'h01);
      chk({7'h00, engineCmd.skipCoarse}, 8'h01);
      sample = 12'h0c0;
      repeat (60) @(negedge core_clk);
      rc(8'h30, 8'h05);
      chk({5'h00, engineCmd.updateOffset, engineCmd.updateGain, engineCmd.updateSkew}, 8'h04);
      sample = 12'h7ff;
      repeat (60) @(negedge core_clk);
      rc(8'h30, 8'h04);
      acLowPower = 1'b1;
      repeat (3) @(negedge core_clk);
      rc(8'h30, 8'h06);
      acLowPower = 1'b0;
      hostU.wr(8'h31, 8'h03);
      chk({5'h00, engineCmd.updateOffset, engineCmd.updateGain, engineCmd.updateSkew}, 8'h00);
      hostU.wr(8'h31, 8'h05);
      rc(8'h31, 8'h05);
      rc(8'h30, 8'h04);
      chk({5'h00, engineCmd.updateOffset, engineCmd.updateGain, engineCmd.updateSkew}, 8'h03);
      hostU.wr(8'h31, 8'h00);
      @(negedge core_clk);
      chk({7'h00, engineCmd.engineActive}, 8'h00);
      hostU.wr(8'h4a, 8'h01);
      chk({6'h00, engineCmd.algPowerDown, engineCmd.notchPowerDown}, 8'h02);
      $display("t_engine done");
   endtask
   initial begin
      repeat (4) @(negedge core_clk);
      nrst = 1'b1;
      t_power();
      t_trims();
      t_engine();
      wrap_up();
   end
endmodule // tb
bind icc_regs icc_regs_asserts chkU (.core_clk(core_clk), .nrst(nrst), .regReq(regReq),
   .softReset(softReset), .adjustEnable(adjustEnable), .calLoad(calLoad),
   .acLowPower(acLowPower), .powerState(powerState), .appliedTrims(appliedTrims),
   .engineCmd(engineCmd));
